// ### epc_port.v
// Pin control for an eight-bit general-purpose port with alternate functions.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "epc_map.vh"

//
// Function
// RQ1: Per-pin output enable bits 7..0; one enables driver; reset zero.
// RQ2: Function select one bits 7..4 route timer3 out/in, timer2 out/in.
// RQ3: Function select one bit3 timer4 out; bits 2..0 serial0 clock, receive, transmit.
// RQ4: Function select two bits 7,6,4 external interrupts; bit2 clear-to-send; others zero.
// RQ5: Per-pin driver type; zero push-pull, one open-drain; reset zero.
// RQ6: Per-pin pull-up enable bits; one enables; reset zero.
// RQ7: Per-pin pull-down enable bits; one enables; reset zero.
// RQ8: After reset all pins are plain port pins, everything disabled.
// RQ9: Bits 31..8 of every register read zero; writes there ignored.
module epc_port (
    // Clock, enable, reset
    input  wire        i_clk_sys,
    input  wire        i_ce,
    input  wire        i_rst,
    // Register port
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata_ff,
    // Port data from the data register and pads
    input  wire [7:0]  i_port_out,
    input  wire [7:0]  i_pad_in,
    // Peripheral outputs routed to pins
    input  wire        i_timer_ch3_output,
    input  wire        i_timer_ch2_output,
    input  wire        i_timer_ch4_output,
    input  wire        i_serial0_clock_out,
    input  wire        i_serial0_clock_oe,
    input  wire        i_serial0_transmit,
    // Pad controls
    output reg  [7:0]  o_pad_out_ff,
    output reg  [7:0]  o_pad_oe_ff,
    output reg  [7:0]  o_pad_pullup_ff,
    output reg  [7:0]  o_pad_pulldown_ff,
    // Peripheral inputs taken from pins
    output reg         o_timer_ch3_input_ff,
    output reg         o_timer_ch2_input_ff,
    output reg         o_serial0_clock_in_ff,
    output reg         o_serial0_receive_ff,
    output reg         o_serial0_clear_to_send_ff,
    output reg         o_ext_interrupt_seven_ff,
    output reg         o_ext_interrupt_six_ff,
    output reg         o_ext_interrupt_five_ff
);

    // ========================================================================
    // Register file
    // ========================================================================
    wire [7:0] pin_output_enable;
    wire [7:0] pin_function_select_one;
    wire [7:0] pin_function_select_two;
    wire [7:0] pin_driver_type;
    wire [7:0] pin_pullup_enable;
    wire [7:0] pin_pulldown_enable;

    function wr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = i_wr && (addr == ofs);
        end
    endfunction

    // Only the low byte of the write data is stored.
    epc_reg8 #(.WMASK(`EPC_MASK_ALL)) u_out_en ( // RQ1 RQ9
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_we      (wr_hit(i_addr, `EPC_OFS_OUT_EN)),
        .i_wdata   (i_wdata[7:0]),
        .o_q_ff    (pin_output_enable)
    );

    epc_reg8 #(.WMASK(`EPC_MASK_ALL)) u_func_one ( // RQ2 RQ3
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_we      (wr_hit(i_addr, `EPC_OFS_FUNC_ONE)),
        .i_wdata   (i_wdata[7:0]),
        .o_q_ff    (pin_function_select_one)
    );

    epc_reg8 #(.WMASK(`EPC_MASK_FUNC_TWO)) u_func_two ( // RQ4
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_we      (wr_hit(i_addr, `EPC_OFS_FUNC_TWO)),
        .i_wdata   (i_wdata[7:0]),
        .o_q_ff    (pin_function_select_two)
    );

    epc_reg8 #(.WMASK(`EPC_MASK_ALL)) u_drv_type ( // RQ5
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_we      (wr_hit(i_addr, `EPC_OFS_DRV_TYPE)),
        .i_wdata   (i_wdata[7:0]),
        .o_q_ff    (pin_driver_type)
    );

    epc_reg8 #(.WMASK(`EPC_MASK_ALL)) u_pullup ( // RQ6
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_we      (wr_hit(i_addr, `EPC_OFS_PULLUP)),
        .i_wdata   (i_wdata[7:0]),
        .o_q_ff    (pin_pullup_enable)
    );

    epc_reg8 #(.WMASK(`EPC_MASK_ALL)) u_pulldown ( // RQ7
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_we      (wr_hit(i_addr, `EPC_OFS_PULLDOWN)),
        .i_wdata   (i_wdata[7:0]),
        .o_q_ff    (pin_pulldown_enable)
    );

    // ========================================================================
    // Read path
    // ========================================================================
    reg [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = `EPC_RST_WORD;
        case (i_addr)
            `EPC_OFS_OUT_EN:   nxt_rdata = {24'h00_0000, pin_output_enable}; // RQ9
            `EPC_OFS_FUNC_ONE: nxt_rdata = {24'h00_0000, pin_function_select_one};
            `EPC_OFS_FUNC_TWO: nxt_rdata = {24'h00_0000, pin_function_select_two}; // RQ4
            `EPC_OFS_DRV_TYPE: nxt_rdata = {24'h00_0000, pin_driver_type};
            `EPC_OFS_PULLUP:   nxt_rdata = {24'h00_0000, pin_pullup_enable};
            `EPC_OFS_PULLDOWN: nxt_rdata = {24'h00_0000, pin_pulldown_enable};
            default:           nxt_rdata = `EPC_RST_WORD;
        endcase
    end

    // Read data stand for exactly one cycle after the strobe, zero otherwise.
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata_ff <= `EPC_RST_WORD;
        end else if (i_ce) begin
            o_rdata_ff <= i_rd ? nxt_rdata : `EPC_RST_WORD;
        end
    end

    // ========================================================================
    // Pin multiplexing
    // ========================================================================
    reg [7:0] nxt_src;
    reg [7:0] nxt_drive;
    reg [7:0] nxt_out;
    reg [7:0] nxt_oe;

    always @* begin
        nxt_src = i_port_out;
        nxt_drive = pin_output_enable; // RQ1
        if (pin_function_select_one[`EPC_F1_TMR3_OUT]) begin // RQ2
            nxt_src[`EPC_F1_TMR3_OUT] = i_timer_ch3_output;
        end
        if (pin_function_select_one[`EPC_F1_TMR2_OUT]) begin // RQ2
            nxt_src[`EPC_F1_TMR2_OUT] = i_timer_ch2_output;
        end
        if (pin_function_select_one[`EPC_F1_TMR4_OUT]) begin // RQ3
            nxt_src[`EPC_F1_TMR4_OUT] = i_timer_ch4_output;
        end
        // The serial clock pin is bidirectional; its master decides direction.
        if (pin_function_select_one[`EPC_F1_SER0_CLK]) begin // RQ3
            nxt_src[`EPC_F1_SER0_CLK] = i_serial0_clock_out;
            nxt_drive[`EPC_F1_SER0_CLK] = pin_output_enable[`EPC_F1_SER0_CLK] & i_serial0_clock_oe;
        end
        if (pin_function_select_one[`EPC_F1_SER0_TX]) begin // RQ3
            nxt_src[`EPC_F1_SER0_TX] = i_serial0_transmit;
        end
        // Open drain drives only a low; a high releases the pin to the pull-up.
        nxt_out = nxt_src & ~pin_driver_type; // RQ5
        nxt_oe = nxt_drive & ~(pin_driver_type & nxt_src); // RQ5
    end

    // ========================================================================
    // Output flip-flops
    // ========================================================================
    always @(posedge i_clk_sys) begin
        if (i_rst) begin // RQ8
            o_pad_out_ff               <= `EPC_RST_BYTE;
            o_pad_oe_ff                <= `EPC_RST_BYTE;
            o_pad_pullup_ff            <= `EPC_RST_BYTE;
            o_pad_pulldown_ff          <= `EPC_RST_BYTE;
            o_timer_ch3_input_ff       <= 1'b0;
            o_timer_ch2_input_ff       <= 1'b0;
            o_serial0_clock_in_ff      <= 1'b0;
            o_serial0_receive_ff       <= 1'b0;
            o_serial0_clear_to_send_ff <= 1'b0;
            o_ext_interrupt_seven_ff   <= 1'b0;
            o_ext_interrupt_six_ff     <= 1'b0;
            o_ext_interrupt_five_ff    <= 1'b0;
        end else if (i_ce) begin
            o_pad_out_ff      <= nxt_out;
            o_pad_oe_ff       <= nxt_oe; // RQ1
            o_pad_pullup_ff   <= pin_pullup_enable; // RQ6
            o_pad_pulldown_ff <= pin_pulldown_enable; // RQ7
            // A deselected function input sees a steady low.
            o_timer_ch3_input_ff  <= pin_function_select_one[`EPC_F1_TMR3_IN] & i_pad_in[`EPC_F1_TMR3_IN]; // RQ2
            o_timer_ch2_input_ff  <= pin_function_select_one[`EPC_F1_TMR2_IN] & i_pad_in[`EPC_F1_TMR2_IN]; // RQ2
            o_serial0_clock_in_ff <= pin_function_select_one[`EPC_F1_SER0_CLK] & i_pad_in[`EPC_F1_SER0_CLK]; // RQ3
            o_serial0_receive_ff  <= pin_function_select_one[`EPC_F1_SER0_RX] & i_pad_in[`EPC_F1_SER0_RX]; // RQ3
            o_serial0_clear_to_send_ff <= pin_function_select_two[`EPC_F2_SER0_CTS]
                                          & i_pad_in[`EPC_F2_SER0_CTS]; // RQ4
            o_ext_interrupt_seven_ff <= pin_function_select_two[`EPC_F2_EXT_EXT_INTERRUPT_SEVEN] & i_pad_in[`EPC_F2_EXT_EXT_INTERRUPT_SEVEN]; // RQ4
            o_ext_interrupt_six_ff   <= pin_function_select_two[`EPC_F2_EXT_EXT_INTERRUPT_SIX] & i_pad_in[`EPC_F2_EXT_EXT_INTERRUPT_SIX]; // RQ4
            o_ext_interrupt_five_ff  <= pin_function_select_two[`EPC_F2_EXT_EXT_INTERRUPT_FIVE] & i_pad_in[`EPC_F2_EXT_EXT_INTERRUPT_FIVE]; // RQ4
        end
    end

endmodule // epc_port

// ### epc_map.vh
// Register map and field constants for the eight-bit port pin control block.
`ifndef EPC_MAP_VH
`define EPC_MAP_VH

// ============================================================================
// Register offsets (byte addresses)
// ============================================================================
`define EPC_OFS_OUT_EN      8'h04
`define EPC_OFS_FUNC_ONE    8'h08
`define EPC_OFS_FUNC_TWO    8'h0c
`define EPC_OFS_DRV_TYPE    8'h28
`define EPC_OFS_PULLUP      8'h2c
`define EPC_OFS_PULLDOWN    8'h30

// ============================================================================
// Reset values and masks
// ============================================================================
`define EPC_RST_BYTE        8'h00
`define EPC_RST_WORD        32'h0000_0000
`define EPC_MASK_ALL        8'hff
`define EPC_MASK_FUNC_TWO   8'hd4

// ============================================================================
// Function select one fields
// ============================================================================
`define EPC_F1_TMR3_OUT     7
`define EPC_F1_TMR3_IN      6
`define EPC_F1_TMR2_OUT     5
`define EPC_F1_TMR2_IN      4
`define EPC_F1_TMR4_OUT     3
`define EPC_F1_SER0_CLK     2
`define EPC_F1_SER0_RX      1
`define EPC_F1_SER0_TX      0

// ============================================================================
// Function select two fields
// ============================================================================
`define EPC_F2_EXT_EXT_INTERRUPT_SEVEN     7
`define EPC_F2_EXT_EXT_INTERRUPT_SIX     6
`define EPC_F2_EXT_EXT_INTERRUPT_FIVE     4
`define EPC_F2_SER0_CTS     2

`endif

// ### epc_reg8.v
// One eight-bit control register with a write mask and clock enable.
`timescale 1ns/1ps

module epc_reg8 #(
    parameter [7:0] WMASK = 8'hff
) (
    // Clock and reset
    input  wire       i_clk_sys,
    input  wire       i_rst,
    input  wire       i_ce,
    // Write port
    input  wire       i_we,
    input  wire [7:0] i_wdata,
    // Stored value
    output reg  [7:0] o_q_ff
);

    // ========================================================================
    // Storage
    // ========================================================================
    // Masked bits never store, so they read as zero.
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_q_ff <= 8'h00;
        end else if (i_ce && i_we) begin
            o_q_ff <= i_wdata & WMASK;
        end
    end

endmodule // epc_reg8

// ### epc_port_assertions.sv
// Concurrent checks on the port pin control block.
`timescale 1ns/1ps

module epc_port_assertions (
    // Clock and reset
    input wire        i_clk_sys,
    input wire        i_rst,
    input wire        i_ce,
    // Register port
    input wire [7:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [31:0] o_rdata_ff,
    // Pins
    input wire [7:0]  i_pad_in,
    input wire [7:0]  o_pad_oe_ff,
    input wire [7:0]  o_pad_pullup_ff,
    input wire [7:0]  o_pad_pulldown_ff,
    input wire        o_serial0_receive_ff,
    input wire        o_ext_interrupt_seven_ff
);
    // ========================================================================
    // Checks
    default clocking dc @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    idle_read_zero_a: assert property (!$past(i_rd) |-> o_rdata_ff == 32'h0)
        else $error("read data not zero outside a read");
    upper_bits_zero_a: assert property (o_rdata_ff[31:8] == 24'h0)
        else $error("upper read bits not zero");
    func_two_gaps_a: assert property ($past(i_rd) && $past(i_addr) == 8'h0c |-> (o_rdata_ff[7:0] & 8'h2b) == 8'h0)
        else $error("unused function two bits read as one");
    reset_quiet_a: assert property ($past(i_rst) |-> (o_pad_oe_ff | o_pad_pullup_ff | o_pad_pulldown_ff) == 8'h0)
        else $error("pins active after reset");
    oe_readback_a: assert property (i_ce && i_wr && i_addr == 8'h04 ##1 i_ce && i_rd && i_addr == 8'h04
                                    |=> o_rdata_ff[7:0] == $past(i_wdata[7:0], 2))
        else $error("output enable readback wrong");
    pullup_follow_a: assert property (i_ce && i_wr && i_addr == 8'h2c |-> ##2 o_pad_pullup_ff == $past(i_wdata[7:0], 2))
        else $error("pull-up pins do not follow register");
    pulldown_follow_a: assert property (i_ce && i_wr && i_addr == 8'h30 |-> ##2 o_pad_pulldown_ff == $past(i_wdata[7:0], 2))
        else $error("pull-down pins do not follow register");
    ext_int_gated_a: assert property (o_ext_interrupt_seven_ff |-> $past(i_pad_in[7]))
        else $error("interrupt seven high without pad level");
    rx_gated_a: assert property (o_serial0_receive_ff |-> $past(i_pad_in[1]))
        else $error("receive high without pad level");
endmodule // epc_port_assertions

// ### epc_pins_model.sv
// Pads and board wiring seen by the port pin control block.
`timescale 1ns/1ps

module epc_pins_model (
    // Clock
    input  wire       i_clk_sys,
    // Pad controls from the block
    input  wire [7:0] i_pad_out,
    input  wire [7:0] i_pad_oe,
    input  wire [7:0] i_pullup,
    input  wire [7:0] i_pulldown,
    // Board drivers
    input  wire [7:0] i_ext_en,
    input  wire [7:0] i_ext_val,
    // Resolved pad levels
    output reg  [7:0] o_pad_in
);
    // A pad nobody drives or pulls toggles, so a stale level never passes for a real one.
    reg     [7:0] flt_ff = 8'h55;
    integer       i;

    always @(posedge i_clk_sys) flt_ff <= ~flt_ff;

    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            if (i_pad_oe[i]) o_pad_in[i] = i_pad_out[i];
            else if (i_ext_en[i]) o_pad_in[i] = i_ext_val[i];
            else if (i_pullup[i]) o_pad_in[i] = 1'b1;
            else if (i_pulldown[i]) o_pad_in[i] = 1'b0;
            else o_pad_in[i] = flt_ff[i];
        end
    end
endmodule // epc_pins_model

// ### tb_epc_port.sv
// Self-checking bench for the port pin control block.
`timescale 1ns/1ps
`include "epc_map.vh"

module tb_epc_port;
    // ========================================================================
    // Signals
    reg         i_clk_sys = 1'b0;
    reg         i_rst = 1'b1;
    reg         i_ce = 1'b1;
    reg  [7:0]  i_addr = 8'h00;
    reg  [31:0] i_wdata = 32'h0;
    reg         i_wr = 1'b0;
    reg         i_rd = 1'b0;
    reg  [7:0]  i_port_out = 8'h00;
    reg  [7:0]  ext_en = 8'h00;
    reg  [7:0]  ext_val = 8'h00;
    reg  [5:0]  per = 6'h00;
    wire [31:0] o_rdata_ff;
    wire [7:0]  pad_out, pad_oe, pu, pd, pad_in, ins;
    reg  [7:0]  ofs [0:5];
    reg  [7:0]  msk [0:5];
    integer     failures = 0;
    integer     checks = 0;
    integer     i;

    initial forever #5 i_clk_sys = ~i_clk_sys;

    epc_port u_dut (.i_clk_sys(i_clk_sys), .i_ce(i_ce), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata_ff(o_rdata_ff), .i_port_out(i_port_out), .i_pad_in(pad_in),
        .i_timer_ch3_output(per[5]), .i_timer_ch2_output(per[4]), .i_timer_ch4_output(per[3]),
        .i_serial0_clock_out(per[2]), .i_serial0_clock_oe(per[1]), .i_serial0_transmit(per[0]),
        .o_pad_out_ff(pad_out), .o_pad_oe_ff(pad_oe), .o_pad_pullup_ff(pu), .o_pad_pulldown_ff(pd),
        .o_timer_ch3_input_ff(ins[7]), .o_timer_ch2_input_ff(ins[6]), .o_serial0_clock_in_ff(ins[5]),
        .o_serial0_receive_ff(ins[4]), .o_serial0_clear_to_send_ff(ins[3]),
        .o_ext_interrupt_seven_ff(ins[2]), .o_ext_interrupt_six_ff(ins[1]), .o_ext_interrupt_five_ff(ins[0]));

    epc_pins_model u_pins (.i_clk_sys(i_clk_sys), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pullup(pu),
        .i_pulldown(pd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad_in(pad_in));

    // ========================================================================
    // Tasks
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task chk32(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("FAIL %0t read %h expected %h", $time, got, exp);
            end
        end
    endtask

    task chk8(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("FAIL %0t pins %h expected %h", $time, got, exp);
            end
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
            @(posedge i_clk_sys) i_wr <= 1'b0;
        end
    endtask

    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(posedge i_clk_sys) {i_rd, i_addr} <= {1'b1, a};
            @(posedge i_clk_sys) i_rd <= 1'b0;
            #1 chk32(o_rdata_ff, exp);
        end
    endtask

    // Write then read with no gap, as the bus allows.
    task wrrd(input [7:0] a, input [31:0] d, input [31:0] exp);
        begin
            @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
            @(posedge i_clk_sys) {i_wr, i_rd} <= 2'b01;
            @(posedge i_clk_sys) i_rd <= 1'b0;
            #1 chk32(o_rdata_ff, exp);
        end
    endtask

    task settle;
        begin
            repeat (3) @(posedge i_clk_sys);
            #1;
        end
    endtask

    // ========================================================================
    // Sequence
    initial begin
        #200000 failures = failures + 1;
        stop_test;
    end

    initial begin
        {ofs[0], ofs[1], ofs[2]} = {`EPC_OFS_OUT_EN, `EPC_OFS_FUNC_ONE, `EPC_OFS_FUNC_TWO};
        {ofs[3], ofs[4], ofs[5]} = {`EPC_OFS_DRV_TYPE, `EPC_OFS_PULLUP, `EPC_OFS_PULLDOWN};
        {msk[0], msk[1], msk[2]} = {`EPC_MASK_ALL, `EPC_MASK_ALL, `EPC_MASK_FUNC_TWO};
        {msk[3], msk[4], msk[5]} = {`EPC_MASK_ALL, `EPC_MASK_ALL, `EPC_MASK_ALL};
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        #1 chk8(pad_oe | pu | pd | ins, 8'h00);
        for (i = 0; i < 6; i = i + 1) rd(ofs[i], `EPC_RST_WORD);
        $display("test reset values done");
        for (i = 0; i < 6; i = i + 1) begin
            wr(ofs[i], 32'hffff_ffff);
            rd(ofs[i], {24'h0, msk[i]});
            wr(ofs[i], 32'h0);
        end
        wr(8'h38, 32'hffff_ffff);
        rd(8'h38, 32'h0);
        wrrd(`EPC_OFS_OUT_EN, 32'h1234_5a3c, 32'h3c);
        wr(`EPC_OFS_OUT_EN, 32'h0);
        @(posedge i_clk_sys) i_ce <= 1'b0;
        wr(`EPC_OFS_PULLUP, 32'hff);
        i_ce <= 1'b1;
        rd(`EPC_OFS_PULLUP, 32'h0);
        $display("test register masks done");
        i_port_out <= 8'ha5;
        wr(`EPC_OFS_OUT_EN, 32'hff);
        wr(`EPC_OFS_PULLUP, 32'h3c);
        wr(`EPC_OFS_PULLDOWN, 32'hc3);
        settle;
        chk8(pad_out, 8'ha5);
        chk8(pad_oe, 8'hff);
        chk8(pu, 8'h3c);
        chk8(pd, 8'hc3);
        {per, i_port_out} <= {6'b101110, 8'h00};
        wr(`EPC_OFS_FUNC_ONE, 32'had);
        settle;
        chk8(pad_out, 8'h8c);
        per <= 6'b010001;
        settle;
        chk8(pad_out, 8'h21);
        chk8(pad_oe, 8'hfb);
        $display("test pin outputs done");
        i_port_out <= 8'hf0;
        wr(`EPC_OFS_FUNC_ONE, 32'h0);
        wr(`EPC_OFS_DRV_TYPE, 32'hff);
        settle;
        chk8(pad_out, 8'h00);
        chk8(pad_oe, 8'h0f);
        wr(`EPC_OFS_DRV_TYPE, 32'h0);
        wr(`EPC_OFS_OUT_EN, 32'h0);
        {ext_en, ext_val} <= {8'hff, 8'h52};
        wr(`EPC_OFS_FUNC_ONE, 32'h56);
        wr(`EPC_OFS_FUNC_TWO, 32'hd4);
        settle;
        chk8(ins, 8'hd3);
        ext_val <= 8'hff;
        wr(`EPC_OFS_FUNC_ONE, 32'h0);
        wr(`EPC_OFS_FUNC_TWO, 32'h0);
        settle;
        chk8(ins, 8'h00);
        $display("test pin inputs done");
        stop_test;
    end
endmodule // tb_epc_port

bind epc_port epc_port_assertions u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata_ff(o_rdata_ff), .i_pad_in(i_pad_in), .o_pad_oe_ff(o_pad_oe_ff),
    .o_pad_pullup_ff(o_pad_pullup_ff), .o_pad_pulldown_ff(o_pad_pulldown_ff),
    .o_serial0_receive_ff(o_serial0_receive_ff), .o_ext_interrupt_seven_ff(o_ext_interrupt_seven_ff));
